// [design/fcu_top.sv]
// How it works
// - exact compare, no overflow or underflow
// - write result bit, true 1 false 0
// - paired halves to index and index plus one
// - signaling NaN raises invalid, sets flag
// - signaling predicates also trap quiet NaN
// - enabled invalid suppresses write, traps
// - any NaN gives unordered only
// - plus and minus zero compare equal
// - result from less, equal, unordered terms
// - low bits pick eight quiet predicates
// - top bit picks eight signaling predicates
// - paired half exceptions are ORed together
// - unusable, reserved, unimplemented, invalid exceptions
// - implicit index targets condition code zero
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "fcu_defs.svh"

module fcu_top
    import fcu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fcu_req_type req,
    input wire logic cop_usable,
    input wire logic fr_mode_64,
    input wire fcu_bus_type bus,
    output logic [31:0] rdata,
    output logic [7:0] cc_out,
    output logic done,
    output logic exc_valid,
    output fcu_exc_type exc_code,
    output logic irq
);

    fcu_state_type st_r;
    fcu_state_type st_nxt;

    fcu_rel_type rel_d;
    fcu_rel_type rel_s [2];

    logic is_s;
    logic is_d;
    logic is_ps;
    logic [2:0] lo_idx;
    logic [2:0] hi_idx;
    fcu_rel_type lo_rel;
    fcu_rel_type hi_rel;
    logic lo_res;
    logic hi_res;
    logic inv_lo;
    logic inv_hi;
    logic inv_raise;
    fcu_exc_type exc_sel;
    logic [2:0] events;

    // predicate value for one relation set
    function automatic logic pred(input logic [3:0] c, input fcu_rel_type r);
        pred = (c[`FCU_COND_LT] && r.less)
            || (c[`FCU_COND_EQ] && r.equal)
            || (c[`FCU_COND_UN] && r.unord);
    endfunction

    // invalid condition for one relation set
    function automatic logic inv_of(input logic [3:0] c, input fcu_rel_type r);
        inv_of = r.snan
            || (c[`FCU_COND_SIG] && r.qnan);
    endfunction

    fcu_cmp #(
        .W(64),
        .EW(11)
    ) u_cmp_d (
        .a(req.first_source_fpr),
        .b(req.second_source_fpr),
        .rel(rel_d)
    );

    // halves: 0 lower single, 1 upper single
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_half
            fcu_cmp #(
                .W(32),
                .EW(8)
            ) u_cmp_s (
                .a(req.first_source_fpr[32*g +: 32]),
                .b(req.second_source_fpr[32*g +: 32]),
                .rel(rel_s[g])
            );
        end
    endgenerate

    // operation decode and result evaluation
    always_comb begin
        is_s = req.fmt == `FCU_FMT_S;
        is_d = req.fmt == `FCU_FMT_D;
        is_ps = req.fmt == `FCU_FMT_PS;
        // implicit form targets code zero
        lo_idx = req.cc_explicit ? req.fp_condition_code_index : 3'h0;
        hi_idx = lo_idx + 3'h1;
        lo_rel = is_d ? rel_d : rel_s[0];
        hi_rel = rel_s[1];
        // cond low bits choose the predicate, top bit its signaling kind
        lo_res = pred(req.cond, lo_rel);
        hi_res = pred(req.cond, hi_rel);
        inv_lo = inv_of(req.cond, lo_rel);
        inv_hi = is_ps && inv_of(req.cond, hi_rel);
        inv_raise = inv_lo || inv_hi;
        // priority of the exception outcome
        if (!cop_usable) begin
            exc_sel = FCU_EXC_COP_UNUSABLE;
        end else if (!(is_s || is_d || is_ps)) begin
            exc_sel = FCU_EXC_RESERVED;
        end else if (is_ps && !fr_mode_64) begin
            exc_sel = FCU_EXC_UNIMPL;
        end else if (inv_raise && st_r.inv_en) begin
            exc_sel = FCU_EXC_INVALID;
        end else begin
            exc_sel = FCU_EXC_NONE;
        end
    end

    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.exc_valid = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        events = 3'h0;

        // register reads, data stand next cycle
        if (bus.rd) begin
            case (bus.addr)
                `FCU_OFS_CTRL: begin
                    st_nxt.rdata[`FCU_CTRL_INV_EN] = st_r.inv_en;
                    st_nxt.rdata[`FCU_CTRL_INV_FLAG] = st_r.inv_flag;
                    st_nxt.rdata[`FCU_CTRL_INV_CAUSE] = st_r.inv_cause;
                end
                `FCU_OFS_CC: begin
                    st_nxt.rdata[7:0] = st_r.cc;
                end
                `FCU_OFS_ISTAT: begin
                    st_nxt.rdata[2:0] = st_r.istat;
                    st_nxt.istat = 3'h0;
                end
                `FCU_OFS_IMASK: begin
                    st_nxt.rdata[2:0] = st_r.imask;
                end
                `FCU_OFS_REL: begin
                    st_nxt.rdata[5:0] = st_r.last_rel;
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // register writes
        if (bus.wr) begin
            case (bus.addr)
                `FCU_OFS_CTRL: begin
                    st_nxt.inv_en = bus.wdata[`FCU_CTRL_INV_EN];
                    st_nxt.inv_flag = bus.wdata[`FCU_CTRL_INV_FLAG];
                    st_nxt.inv_cause = bus.wdata[`FCU_CTRL_INV_CAUSE];
                end
                `FCU_OFS_CC: begin
                    st_nxt.cc = bus.wdata[7:0];
                end
                `FCU_OFS_IMASK: begin
                    st_nxt.imask = bus.wdata[2:0];
                end
                default: begin
                    st_nxt.imask = st_nxt.imask;
                end
            endcase
        end

        // compare issue; hardware updates win over software
        if (req.valid) begin
            st_nxt.done = 1'b1;
            events[`FCU_IRQ_DONE] = 1'b1;
            if (exc_sel == FCU_EXC_NONE || exc_sel == FCU_EXC_INVALID) begin
                st_nxt.last_rel = {hi_rel.less, hi_rel.equal, hi_rel.unord,
                                   lo_rel.less, lo_rel.equal, lo_rel.unord};
                st_nxt.inv_cause = inv_raise;
                if (inv_raise) begin
                    st_nxt.inv_flag = 1'b1;
                    events[`FCU_IRQ_INV] = 1'b1;
                end
            end
            if (exc_sel == FCU_EXC_NONE) begin
                st_nxt.cc[lo_idx] = lo_res;
                if (is_ps) begin
                    st_nxt.cc[hi_idx] = hi_res;
                end
            end else begin
                st_nxt.exc_valid = 1'b1;
                events[`FCU_IRQ_EXC] = 1'b1;
            end
            st_nxt.exc_code = exc_sel;
        end

        // sticky status: set wins over read clear
        st_nxt.istat = st_nxt.istat | events;
        st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r.cc <= `FCU_RST_CC;
            st_r.inv_en <= `FCU_RST_INV_EN;
            st_r.inv_flag <= 1'b0;
            st_r.inv_cause <= 1'b0;
            st_r.istat <= 3'h0;
            st_r.imask <= `FCU_RST_IMASK;
            st_r.last_rel <= 6'h00;
            st_r.rdata <= 32'h0000_0000;
            st_r.done <= 1'b0;
            st_r.exc_valid <= 1'b0;
            st_r.exc_code <= FCU_EXC_NONE;
            st_r.irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign cc_out = st_r.cc;
    assign done = st_r.done;
    assign exc_valid = st_r.exc_valid;
    assign exc_code = st_r.exc_code;
    assign irq = st_r.irq;

endmodule

`default_nettype wire

// [design/fcu_defs.svh]
`ifndef FCU_DEFS_SVH
`define FCU_DEFS_SVH

// register offsets (byte addresses)
`define FCU_OFS_CTRL 8'h00
`define FCU_OFS_CC 8'h04
`define FCU_OFS_ISTAT 8'h08
`define FCU_OFS_IMASK 8'h0C
`define FCU_OFS_REL 8'h10

// control/status field positions
`define FCU_CTRL_INV_EN 0
`define FCU_CTRL_INV_FLAG 1
`define FCU_CTRL_INV_CAUSE 2

// interrupt status field positions
`define FCU_IRQ_DONE 0
`define FCU_IRQ_INV 1
`define FCU_IRQ_EXC 2

// reset values
`define FCU_RST_CC 8'h00
`define FCU_RST_IMASK 3'h0
`define FCU_RST_INV_EN 1'b0

// operand format codes
`define FCU_FMT_S 5'h10
`define FCU_FMT_D 5'h11
`define FCU_FMT_PS 5'h16

// condition field bit positions
`define FCU_COND_SIG 3
`define FCU_COND_LT 2
`define FCU_COND_EQ 1
`define FCU_COND_UN 0

`endif

// [design/fcu_pkg.sv]
package fcu_pkg;

    typedef struct packed {
        logic snan;
        logic qnan;
        logic unord;
        logic less;
        logic equal;
    } fcu_rel_type;

    typedef enum logic [2:0] {
        FCU_EXC_NONE = 3'h0,
        FCU_EXC_COP_UNUSABLE = 3'h1,
        FCU_EXC_RESERVED = 3'h2,
        FCU_EXC_UNIMPL = 3'h3,
        FCU_EXC_INVALID = 3'h4
    } fcu_exc_type;

    typedef struct packed {
        logic valid;
        logic [4:0] fmt;
        logic [3:0] cond;
        logic [2:0] fp_condition_code_index;
        logic cc_explicit;
        logic [63:0] first_source_fpr;
        logic [63:0] second_source_fpr;
    } fcu_req_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } fcu_bus_type;

    typedef struct packed {
        logic [7:0] cc;
        logic inv_en;
        logic inv_flag;
        logic inv_cause;
        logic [2:0] istat;
        logic [2:0] imask;
        logic [5:0] last_rel;
        logic [31:0] rdata;
        logic done;
        logic exc_valid;
        fcu_exc_type exc_code;
        logic irq;
    } fcu_state_type;

endpackage

// [design/fcu_cmp.sv]
`timescale 1ns/1ns
`default_nettype none

module fcu_cmp
    import fcu_pkg::*;
#(
    parameter int W = 32,
    parameter int EW = 8
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output fcu_rel_type rel
);

    localparam int FW = W - 1 - EW;

    logic a_nan;
    logic b_nan;
    logic a_zero;
    logic b_zero;
    logic mag_lt;
    logic mag_gt;

    always_comb begin
        a_nan = (&a[W-2:FW]) && (|a[FW-1:0]);
        b_nan = (&b[W-2:FW]) && (|b[FW-1:0]);
        a_zero = ~|a[W-2:0];
        b_zero = ~|b[W-2:0];
        mag_lt = a[W-2:0] < b[W-2:0];
        mag_gt = a[W-2:0] > b[W-2:0];
        // quiet when top fraction bit is set
        rel.snan = (a_nan && !a[FW-1]) || (b_nan && !b[FW-1]);
        rel.qnan = (a_nan && a[FW-1]) || (b_nan && b[FW-1]);
        // exact compare, no rounding path
        rel.unord = a_nan || b_nan;
        rel.equal = 1'b0;
        rel.less = 1'b0;
        if (!rel.unord) begin
            if (a_zero && b_zero) begin
                rel.equal = 1'b1;
            end else if (a[W-1] != b[W-1]) begin
                rel.less = a[W-1];
            end else if (a[W-1]) begin
                rel.less = mag_gt;
                rel.equal = !mag_gt && !mag_lt;
            end else begin
                rel.less = mag_lt;
                rel.equal = !mag_gt && !mag_lt;
            end
        end
    end

endmodule

`default_nettype wire

// [dv/fcu_top_properties.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fcu_defs.svh"
module fcu_top_properties
    import fcu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fcu_req_type req,
    input wire logic cop_usable,
    input wire logic fr_mode_64,
    input wire fcu_bus_type bus,
    input wire logic [31:0] rdata,
    input wire logic [7:0] cc_out,
    input wire logic done,
    input wire logic exc_valid,
    input wire fcu_exc_type exc_code,
    input wire logic irq
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_issue;
        req.valid ##1 done;
    endsequence
    AST_DONE: assert property (req.valid |-> s_issue) else $error("done missing");
    AST_IDLE: assert property (!req.valid |=> !done && !exc_valid) else $error("stray done");
    AST_EXCV: assert property (exc_valid |-> done && exc_code != FCU_EXC_NONE)
        else $error("exception without code");
    AST_COPU: assert property (req.valid && !cop_usable |=> exc_valid
        && exc_code == FCU_EXC_COP_UNUSABLE) else $error("unusable not taken");
    AST_PS16: assert property (req.valid && cop_usable && req.fmt == `FCU_FMT_PS && !fr_mode_64
        && !bus.wr |=> exc_code == FCU_EXC_UNIMPL && $stable(cc_out)) else $error("paired trap");
    AST_FALSE: assert property (req.valid && req.fmt == `FCU_FMT_S && req.cond[2:0] == 3'h0
        && !req.cc_explicit |=> exc_valid || !cc_out[0]) else $error("false gave true");
    AST_HOLD: assert property (!req.valid |=> $stable(exc_code)) else $error("code moved");
    AST_ZERO: assert property (req.valid && cop_usable && req.fmt == `FCU_FMT_S && req.cond == 4'h2
        && !req.cc_explicit && req.first_source_fpr[30:0] == 31'h0
        && req.second_source_fpr[30:0] == 31'h0 |=> cc_out[0]) else $error("zeros unequal");
endmodule
bind fcu_top fcu_top_properties u_fcu_top_properties(.sys_clk, .rst, .req, .cop_usable,
    .fr_mode_64, .bus, .rdata, .cc_out, .done, .exc_valid, .exc_code, .irq);
`default_nettype wire

// [dv/fcu_issue_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fcu_issue_model
    import fcu_pkg::*;
(
    input wire logic sys_clk,
    output fcu_req_type req
);
    initial req = '0;
    // one-cycle issue; released fields scrambled, valid drops
    task automatic issue(input fcu_req_type q);
        @(posedge sys_clk);
        req <= q;
        @(posedge sys_clk);
        req <= ~q;
    endtask
endmodule
`default_nettype wire

// [dv/fcu_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fcu_defs.svh"
module fcu_top_tb_top
    import fcu_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cop_usable = 1'b1;
    logic fr_mode_64 = 1'b1;
    fcu_bus_type bus = '0;
    fcu_req_type req;
    logic [31:0] rdata, v;
    logic [7:0] cc_out, xcc = 8'h00;
    logic done, exc_valid, irq, inv_en = 1'b0, flag = 1'b0, cause = 1'b0;
    fcu_exc_type exc_code;
    int fail_count = 0, n_compared = 0, seed = 38, k;
    logic [4:0] f;
    logic [63:0] a, b;
    logic [31:0] sv [8] = '{32'h0, 32'h80000000, 32'h3F800000, 32'hBF800000,
        32'h7F800000, 32'h7FC00000, 32'h7F800001, 32'h40000000};
    logic [63:0] dv [8] = '{64'h0, 64'h8000000000000000, 64'h3FF0000000000000,
        64'hBFF0000000000000, 64'h7FF0000000000000, 64'h7FF8000000000000,
        64'h7FF0000000000001, 64'h4000000000000000};
    logic [4:0] fm [4] = '{`FCU_FMT_S, `FCU_FMT_D, `FCU_FMT_PS, 5'h14};

    fcu_top u_fcu_top(.sys_clk, .rst, .req, .cop_usable, .fr_mode_64, .bus, .rdata, .cc_out,
        .done, .exc_valid, .exc_code, .irq);
    fcu_issue_model u_fcu_issue_model(.sys_clk, .req);

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{1'b1, 1'b0, ad, d};
        @(posedge sys_clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] ad);
        @(posedge sys_clk);
        bus <= '{1'b0, 1'b1, ad, 32'h0};
        @(posedge sys_clk);
        bus <= '0;
        @(negedge sys_clk);
        v = rdata;
    endtask

    function automatic fcu_rel_type rel(input logic [63:0] a, input logic [63:0] b, input logic d);
        logic [63:0] m, inf, ma, mb;
        int w, s;
        fcu_rel_type r;
        w = d ? 52 : 23;
        s = d ? 63 : 31;
        m = (64'h1 << s) - 64'h1;
        inf = m & ~((64'h1 << w) - 64'h1);
        ma = a & m;
        mb = b & m;
        r.snan = (ma > inf && !a[w-1]) || (mb > inf && !b[w-1]);
        r.qnan = (ma > inf && a[w-1]) || (mb > inf && b[w-1]);
        r.unord = ma > inf || mb > inf;
        r.equal = !r.unord && ma == mb && (a[s] == b[s] || ma == 64'h0);
        r.less = !r.unord && !r.equal && (a[s] != b[s] ? a[s] : (a[s] ? ma > mb : ma < mb));
        return r;
    endfunction

    function automatic logic pred(input logic [3:0] c, input fcu_rel_type r);
        return (c[2] & r.less) | (c[1] & r.equal) | (c[0] & r.unord);
    endfunction

    task automatic cmp(input fcu_req_type q);
        fcu_rel_type lo, hi;
        fcu_exc_type x;
        logic [2:0] i;
        u_fcu_issue_model.issue(q);
        i = q.cc_explicit ? q.fp_condition_code_index : 3'h0;
        lo = rel(q.first_source_fpr, q.second_source_fpr, q.fmt == `FCU_FMT_D);
        hi = rel(q.first_source_fpr >> 32, q.second_source_fpr >> 32, 1'b0);
        if (q.fmt != `FCU_FMT_PS) hi = '0;
        if (!cop_usable) x = FCU_EXC_COP_UNUSABLE;
        else if (q.fmt != `FCU_FMT_S && q.fmt != `FCU_FMT_D && q.fmt != `FCU_FMT_PS) x = FCU_EXC_RESERVED;
        else if (q.fmt == `FCU_FMT_PS && !fr_mode_64) x = FCU_EXC_UNIMPL;
        else if (inv_en && (lo.snan | hi.snan | (q.cond[3] & (lo.qnan | hi.qnan)))) x = FCU_EXC_INVALID;
        else x = FCU_EXC_NONE;
        if (x == FCU_EXC_NONE || x == FCU_EXC_INVALID) begin
            cause = lo.snan | hi.snan | (q.cond[3] & (lo.qnan | hi.qnan));
            flag = flag | cause;
        end
        if (x == FCU_EXC_NONE) begin
            xcc[i] = pred(q.cond, lo);
            if (q.fmt == `FCU_FMT_PS) xcc[i + 3'h1] = pred(q.cond, hi);
        end
        @(negedge sys_clk);
        chk("done", done, 1);
        chk("cc_out", cc_out, xcc);
        chk("exc_valid", exc_valid, x != FCU_EXC_NONE);
        chk("exc_code", exc_code, x);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`FCU_OFS_CC);
        chk("cc reset", v, 0);
        rd(8'hFC);
        chk("unmapped", v, 0);
        wr(`FCU_OFS_IMASK, 32'h1);
        cmp('{1'b1, `FCU_FMT_S, 4'h2, 3'h3, 1'b0, 64'h0, 64'h80000000});
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irq", irq, 1);
        rd(`FCU_OFS_ISTAT);
        chk("istat", v, 1);
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("irq cleared", irq, 0);
        rd(`FCU_OFS_REL);
        chk("rel", v[2:0], 3'b010);
        wr(`FCU_OFS_IMASK, 32'h0);
        for (int i = 0; i < 32; i++)
            cmp('{1'b1, `FCU_FMT_S, 4'(i), 3'h0, 1'b0, sv[i / 4], sv[(i + 3) % 8]});
        chk("irq masked", irq, 0);
        for (int i = 0; i < 400; i++) begin
            if (i % 50 == 0) begin
                rd(`FCU_OFS_CTRL);
                chk("ctrl", v[2:0], {cause, flag, inv_en});
                inv_en = 1'($random(seed));
                flag = 1'b0;
                cause = 1'b0;
                wr(`FCU_OFS_CTRL, {31'h0, inv_en});
                xcc = 8'($random(seed));
                wr(`FCU_OFS_CC, {24'h0, xcc});
            end
            f = fm[$random(seed) & 3];
            k = $random(seed) & 7;
            a = f == `FCU_FMT_D ? dv[k] : {sv[$random(seed) & 7], sv[k]};
            if (k == 7) a[31:0] = $random(seed);
            k = $random(seed) & 7;
            b = f == `FCU_FMT_D ? dv[k] : {sv[$random(seed) & 7], sv[k]};
            @(posedge sys_clk);
            cop_usable <= ($random(seed) & 15) != 0;
            fr_mode_64 <= ($random(seed) & 7) != 0;
            cmp('{1'b1, f, 4'($random(seed)), 3'($random(seed) & (f == `FCU_FMT_PS ? 6 : 7)),
                1'($random(seed)), a, b});
        end
        stop_test();
    end

    initial begin
        #1_000_000;
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
